// *** host_pins_parallel_io_mux.sv ***
// Pin multiplexer between a host-facing emulated serial port and parallel ports A, B and C.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - In host mode the eight shared data pins form a two-way host data bus.
// - In host mode the driver disable output is low while the host reads.
// - The host puts a register index on three address pins and the device uses it.
// - In host mode the host interrupt output is high while an interrupt is pending.
// - In host DMA mode the transmit-ready output is low while the transmit holding register is empty.
// - In host DMA mode the receive-ready output is low while a received byte waits.
// - Outside host mode each port A line has its own direction.
// - In host mode the port A pins belong to the host data bus.
// - Port B lines are general I/O with own directions only when the port function is chosen.
// - Port C bits 5 to 0 have own directions; bits 7 and 6 are inputs showing the interrupt pins.
// - Writing one to port C bit 7 or 6 clears that edge capture latch; zero does nothing.
// - Configuration bit 7 switches port C between general I/O and serial channel A.
// - Host strobes pass two flip-flops before any logic uses them.
module host_pins_parallel_io_mux
  import pin_mux_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [7:0]  port_a_lines_in,
  output logic      [7:0]  port_a_lines_out,
  output logic      [7:0]  port_a_lines_oe,
  input  wire logic [7:0]  port_b_lines_in,
  output logic      [7:0]  port_b_lines_out,
  output logic      [7:0]  port_b_lines_oe,
  input  wire logic [7:0]  port_c_lines_in,
  output logic      [7:0]  port_c_lines_out,
  output logic      [7:0]  port_c_lines_oe,
  input  wire logic        ext_irq_one_n,
  input  wire logic        ext_irq_two_n,
  input  wire logic        host_select_n,
  input  wire logic        host_write_n,
  input  wire logic        host_read_n,
  input  wire logic [2:0]  host_reg_index,
  input  wire logic [7:0]  serial_b_alt_out,
  input  wire logic [7:0]  serial_b_alt_oe,
  input  wire logic [7:0]  serial_a_alt_out,
  input  wire logic [7:0]  serial_a_alt_oe,
  input  wire logic        alt_tx_b,
  input  wire logic        alt_irq_pin,
  input  wire logic        alt_tx_ready_pin,
  input  wire logic        alt_rx_ready_pin,
  output logic             host_driver_disable_n,
  output logic             host_irq,
  output logic             host_tx_ready_n,
  output logic             host_rx_ready_n
);

  // Two-stage synchronisers for every pin input; stage one feeds only stage two.
  host_pins_t  host_s1_reg, host_s2_reg;
  logic [7:0]  pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg, pc_s1_reg, pc_s2_reg;
  logic [1:0]  ext_s1_reg, ext_s2_reg, ext_prev_reg;

  logic [9:0]  config_reg, config_next;
  logic [7:0]  pa_dir_reg, pa_dir_next, pa_data_reg, pa_data_next;
  logic [7:0]  pb_dir_reg, pb_dir_next, pb_data_reg, pb_data_next;
  logic [7:0]  pc_dir_reg, pc_dir_next, pc_data_reg, pc_data_next;
  logic [1:0]  capture_reg, capture_next;
  logic [3:0]  status_reg, status_next;
  logic [3:0]  irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [7:0]  host_out_reg, host_out_next;
  logic        host_rd_prev_reg, host_wr_prev_reg;
  logic        pready_next;
  logic [31:0] prdata_next;
  logic        pslverr_next;

  pin_drive_t  pa_drive_next, pb_drive_next, pc_drive_next;
  logic        hdis_next, hirq_next, htx_next, hrx_next;

  logic        host_mode;
  logic        host_rd_act, host_wr_act, host_rd_start, host_wr_end;
  logic        apb_wr, apb_rd;
  logic [2:0]  cpu_idx;
  logic [7:0]  mem_rd_host, mem_rd_cpu;
  logic [1:0]  ext_fall;

  assign host_mode = config_reg[CFG_HOST_MODE_BIT];
  assign apb_wr    = psel && penable && pwrite && !pready;
  assign apb_rd    = psel && penable && !pwrite && !pready;
  assign cpu_idx   = paddr[4:2];

  // The host strobes only count while selected and in host mode.
  assign host_rd_act   = host_mode && !host_s2_reg.select_n && !host_s2_reg.read_n;
  assign host_wr_act   = host_mode && !host_s2_reg.select_n && !host_s2_reg.write_n;
  assign host_rd_start = host_rd_act && !host_rd_prev_reg;
  // Data is taken at the end of the write strobe, when the host bus is known to be stable.
  assign host_wr_end   = !host_wr_act && host_wr_prev_reg;
  assign ext_fall      = ext_prev_reg & ~ext_s2_reg;

  host_reg_mem u_host_regs (
    .clk       (clk),
    .rstn      (rstn),
    .wr_en_a   (host_wr_end),
    .wr_idx_a  (host_s2_reg.reg_index),
    .wr_data_a (host_s2_reg.data),
    .wr_en_b   (apb_wr && paddr >= OFF_HOST_REGS && paddr <= 8'h5c && paddr[1:0] == 2'b00),
    .wr_idx_b  (cpu_idx),
    .wr_data_b (pwdata[7:0]),
    .rd_idx_a  (host_s2_reg.reg_index),
    .rd_idx_b  (cpu_idx),
    .rd_data_a (mem_rd_host),
    .rd_data_b (mem_rd_cpu)
  );

  always_comb begin
    config_next   = config_reg;
    pa_dir_next   = pa_dir_reg;
    pa_data_next  = pa_data_reg;
    pb_dir_next   = pb_dir_reg;
    pb_data_next  = pb_data_reg;
    pc_dir_next   = pc_dir_reg;
    pc_data_next  = pc_data_reg;
    capture_next  = capture_reg;
    status_next   = status_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    host_out_next = host_out_reg;
    pready_next   = 1'b0;
    prdata_next   = 32'h0000_0000;
    pslverr_next  = 1'b0;
    // Edge capture latches; a clear that meets a new edge loses to it.
    if (apb_wr && paddr == OFF_PC_DATA) begin
      capture_next = capture_reg & ~pwdata[7:6];
    end
    if (config_reg[EDGE_ONE_BIT] && ext_fall[0]) begin
      capture_next[0] = 1'b1;
    end
    if (config_reg[EDGE_TWO_BIT] && ext_fall[1]) begin
      capture_next[1] = 1'b1;
    end
    if (apb_wr) begin
      pready_next = 1'b1;
      case (paddr)
        OFF_CONFIG:    config_next   = pwdata[9:0];
        OFF_PA_DIR:    pa_dir_next   = pwdata[7:0];
        OFF_PA_DATA:   pa_data_next  = pwdata[7:0];
        OFF_PB_DIR:    pb_dir_next   = pwdata[7:0];
        OFF_PB_DATA:   pb_data_next  = pwdata[7:0];
        OFF_PC_DIR:    pc_dir_next   = {2'b00, pwdata[5:0]};
        OFF_PC_DATA:   pc_data_next  = {2'b00, pwdata[5:0]};
        OFF_HOST_DATA: host_out_next = pwdata[7:0];
        OFF_STATUS:    status_next   = pwdata[3:0];
        OFF_IRQ_MASK:  irq_mask_next = pwdata[3:0];
        default: begin
          if (paddr < OFF_HOST_REGS || paddr[1:0] != 2'b00 || paddr > 8'h5c) begin
            pslverr_next = 1'b1;
          end
        end
      endcase
    end else if (apb_rd) begin
      pready_next = 1'b1;
      case (paddr)
        OFF_CONFIG:    prdata_next = {22'h0, config_reg};
        OFF_PA_DIR:    prdata_next = {24'h0, pa_dir_reg};
        OFF_PA_DATA:   prdata_next = {24'h0, pa_s2_reg};
        OFF_PB_DIR:    prdata_next = {24'h0, pb_dir_reg};
        OFF_PB_DATA:   prdata_next = {24'h0, pb_s2_reg};
        OFF_PC_DIR:    prdata_next = {24'h0, pc_dir_reg};
        OFF_PC_DATA:   prdata_next = {24'h0, ext_s2_reg[1], ext_s2_reg[0], pc_s2_reg[5:0]};
        OFF_HOST_DATA: prdata_next = {24'h0, host_out_reg};
        OFF_STATUS:    prdata_next = {28'h0, status_reg};
        OFF_IRQ_STAT:  prdata_next = {26'h0, capture_reg, irq_stat_reg};
        OFF_IRQ_MASK:  prdata_next = {28'h0, irq_mask_reg};
        default: begin
          if (paddr >= OFF_HOST_REGS && paddr[1:0] == 2'b00 && paddr <= 8'h5c) begin
            prdata_next = {24'h0, mem_rd_cpu};
          end else begin
            pslverr_next = 1'b1;
          end
        end
      endcase
    end
    // Host data-register traffic moves the holding and receive flags.
    if (host_wr_end && host_s2_reg.reg_index == HOST_IDX_DATA) begin
      status_next[ST_THR_EMPTY_BIT] = 1'b0;
    end
    if (host_rd_start && host_s2_reg.reg_index == HOST_IDX_DATA) begin
      status_next[ST_RBR_FULL_BIT] = 1'b0;
    end
    // Read of the status clears it; a new event in the same cycle still sets.
    if (apb_rd && paddr == OFF_IRQ_STAT) begin
      irq_stat_next = 4'h0;
    end
    if (host_wr_end) irq_stat_next[IRQ_HOST_WRITE_BIT] = 1'b1;
    if (host_rd_start) irq_stat_next[IRQ_HOST_READ_BIT] = 1'b1;
    if (capture_next[0] && !capture_reg[0]) irq_stat_next[IRQ_EXT_ONE_BIT] = 1'b1;
    if (capture_next[1] && !capture_reg[1]) irq_stat_next[IRQ_EXT_TWO_BIT] = 1'b1;
  end

  always_comb begin
    // Port A gives way to the host bus in host mode and drives only during host reads.
    if (host_mode) begin
      pa_drive_next.out = host_rd_act ? ((host_s2_reg.reg_index == HOST_IDX_DATA) ?
                          host_out_reg : mem_rd_host) : 8'h00;
      pa_drive_next.oe  = {8{host_rd_act}};
    end else begin
      pa_drive_next.out = pa_data_reg;
      pa_drive_next.oe  = pa_dir_reg;
    end
    if (config_reg[CFG_PORT_B_BIT]) begin
      pb_drive_next.out = pb_data_reg;
      pb_drive_next.oe  = pb_dir_reg;
    end else begin
      pb_drive_next.out = serial_b_alt_out;
      pb_drive_next.oe  = serial_b_alt_oe;
    end
    if (config_reg[CFG_PORT_C_BIT]) begin
      pc_drive_next.out = {2'b00, pc_data_reg[5:0]};
      pc_drive_next.oe  = {2'b00, pc_dir_reg[5:0]};
    end else begin
      pc_drive_next.out = {2'b00, serial_a_alt_out[5:0]};
      pc_drive_next.oe  = {2'b00, serial_a_alt_oe[5:0]};
    end
    if (host_mode) begin
      hdis_next = !host_rd_act;
      hirq_next = status_reg[ST_HOST_IRQ_BIT];
      htx_next  = !(status_reg[ST_DMA_MODE_BIT] && status_reg[ST_THR_EMPTY_BIT]);
      hrx_next  = !(status_reg[ST_DMA_MODE_BIT] && status_reg[ST_RBR_FULL_BIT]);
    end else begin
      hdis_next = alt_tx_b;
      hirq_next = alt_irq_pin;
      htx_next  = alt_tx_ready_pin;
      hrx_next  = alt_rx_ready_pin;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_s1_reg           <= '1;
      host_s2_reg           <= '1;
      pa_s1_reg             <= DATA_RESET;
      pa_s2_reg             <= DATA_RESET;
      pb_s1_reg             <= DATA_RESET;
      pb_s2_reg             <= DATA_RESET;
      pc_s1_reg             <= DATA_RESET;
      pc_s2_reg             <= DATA_RESET;
      ext_s1_reg            <= 2'b11;
      ext_s2_reg            <= 2'b11;
      ext_prev_reg          <= 2'b11;
      host_rd_prev_reg      <= 1'b0;
      host_wr_prev_reg      <= 1'b0;
      config_reg            <= CONFIG_RESET;
      pa_dir_reg            <= DIR_RESET;
      pa_data_reg           <= DATA_RESET;
      pb_dir_reg            <= DIR_RESET;
      pb_data_reg           <= DATA_RESET;
      pc_dir_reg            <= DIR_RESET;
      pc_data_reg           <= DATA_RESET;
      capture_reg           <= 2'b00;
      status_reg            <= STATUS_RESET;
      irq_stat_reg          <= MASK_RESET;
      irq_mask_reg          <= MASK_RESET;
      host_out_reg          <= DATA_RESET;
      pready                <= 1'b0;
      prdata                <= 32'h0000_0000;
      pslverr               <= 1'b0;
      irq                   <= 1'b0;
      port_a_lines_out      <= DATA_RESET;
      port_a_lines_oe       <= DIR_RESET;
      port_b_lines_out      <= DATA_RESET;
      port_b_lines_oe       <= DIR_RESET;
      port_c_lines_out      <= DATA_RESET;
      port_c_lines_oe       <= DIR_RESET;
      host_driver_disable_n <= 1'b1;
      host_irq              <= 1'b0;
      host_tx_ready_n       <= 1'b1;
      host_rx_ready_n       <= 1'b1;
    end else begin
      host_s1_reg           <= {host_select_n, host_write_n, host_read_n, host_reg_index,
                                port_a_lines_in};
      host_s2_reg           <= host_s1_reg;
      pa_s1_reg             <= port_a_lines_in;
      pa_s2_reg             <= pa_s1_reg;
      pb_s1_reg             <= port_b_lines_in;
      pb_s2_reg             <= pb_s1_reg;
      pc_s1_reg             <= port_c_lines_in;
      pc_s2_reg             <= pc_s1_reg;
      ext_s1_reg            <= {ext_irq_two_n, ext_irq_one_n};
      ext_s2_reg            <= ext_s1_reg;
      ext_prev_reg          <= ext_s2_reg;
      host_rd_prev_reg      <= host_rd_act;
      host_wr_prev_reg      <= host_wr_act;
      config_reg            <= config_next;
      pa_dir_reg            <= pa_dir_next;
      pa_data_reg           <= pa_data_next;
      pb_dir_reg            <= pb_dir_next;
      pb_data_reg           <= pb_data_next;
      pc_dir_reg            <= pc_dir_next;
      pc_data_reg           <= pc_data_next;
      capture_reg           <= capture_next;
      status_reg            <= status_next;
      irq_stat_reg          <= irq_stat_next;
      irq_mask_reg          <= irq_mask_next;
      host_out_reg          <= host_out_next;
      pready                <= pready_next;
      prdata                <= prdata_next;
      pslverr               <= pslverr_next;
      irq                   <= |(irq_stat_next & irq_mask_next);
      port_a_lines_out      <= pa_drive_next.out;
      port_a_lines_oe       <= pa_drive_next.oe;
      port_b_lines_out      <= pb_drive_next.out;
      port_b_lines_oe       <= pb_drive_next.oe;
      port_c_lines_out      <= pc_drive_next.out;
      port_c_lines_oe       <= pc_drive_next.oe;
      host_driver_disable_n <= hdis_next;
      host_irq              <= hirq_next;
      host_tx_ready_n       <= htx_next;
      host_rx_ready_n       <= hrx_next;
    end
  end

endmodule : host_pins_parallel_io_mux
`default_nettype wire

// *** pin_mux_pkg.sv ***
// Shared constants, register map and carrier types for the host pin and parallel port block.
package pin_mux_pkg;

  localparam logic [7:0] OFF_CONFIG     = 8'h00;
  localparam logic [7:0] OFF_PA_DIR     = 8'h04;
  localparam logic [7:0] OFF_PA_DATA    = 8'h08;
  localparam logic [7:0] OFF_PB_DIR     = 8'h0c;
  localparam logic [7:0] OFF_PB_DATA    = 8'h10;
  localparam logic [7:0] OFF_PC_DIR     = 8'h14;
  localparam logic [7:0] OFF_PC_DATA    = 8'h18;
  localparam logic [7:0] OFF_HOST_DATA  = 8'h1c;
  localparam logic [7:0] OFF_STATUS     = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h28;
  localparam logic [7:0] OFF_HOST_REGS  = 8'h40;

  localparam int CFG_HOST_MODE_BIT = 1;
  localparam int CFG_PORT_B_BIT    = 2;
  localparam int CFG_PORT_C_BIT    = 7;
  localparam int EDGE_TWO_BIT      = 8;
  localparam int EDGE_ONE_BIT      = 9;

  localparam int IRQ_HOST_WRITE_BIT = 0;
  localparam int IRQ_HOST_READ_BIT  = 1;
  localparam int IRQ_EXT_ONE_BIT    = 2;
  localparam int IRQ_EXT_TWO_BIT    = 3;

  localparam int ST_THR_EMPTY_BIT = 0;
  localparam int ST_RBR_FULL_BIT  = 1;
  localparam int ST_DMA_MODE_BIT  = 2;
  localparam int ST_HOST_IRQ_BIT  = 3;

  localparam logic [9:0] CONFIG_RESET = 10'h000;
  localparam logic [7:0] DIR_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [3:0] STATUS_RESET = 4'h1;
  localparam logic [3:0] MASK_RESET   = 4'h0;

  localparam int HOST_REG_COUNT = 8;
  localparam logic [2:0] HOST_IDX_DATA = 3'h0;

  typedef struct packed {
    logic       select_n;
    logic       write_n;
    logic       read_n;
    logic [2:0] reg_index;
    logic [7:0] data;
  } host_pins_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

endpackage : pin_mux_pkg

// *** host_reg_mem.sv ***
// Small register file holding the emulated controller registers the host reaches.
`timescale 1ns/1ps
`default_nettype none
module host_reg_mem
  import pin_mux_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       wr_en_a,
  input  wire logic [2:0] wr_idx_a,
  input  wire logic [7:0] wr_data_a,
  input  wire logic       wr_en_b,
  input  wire logic [2:0] wr_idx_b,
  input  wire logic [7:0] wr_data_b,
  input  wire logic [2:0] rd_idx_a,
  input  wire logic [2:0] rd_idx_b,
  output logic      [7:0] rd_data_a,
  output logic      [7:0] rd_data_b
);

  logic [7:0] mem_reg  [HOST_REG_COUNT];
  logic [7:0] mem_next [HOST_REG_COUNT];
  logic [7:0] rd_a_next;
  logic [7:0] rd_b_next;

  // Port b is the processor side; a host write to the same entry wins.
  always_comb begin
    for (int i = 0; i < HOST_REG_COUNT; i++) begin
      mem_next[i] = mem_reg[i];
      if (wr_en_b && wr_idx_b == 3'(i)) begin
        mem_next[i] = wr_data_b;
      end
      if (wr_en_a && wr_idx_a == 3'(i)) begin
        mem_next[i] = wr_data_a;
      end
    end
    rd_a_next = mem_reg[rd_idx_a];
    rd_b_next = mem_reg[rd_idx_b];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < HOST_REG_COUNT; i++) begin
        mem_reg[i] <= DATA_RESET;
      end
      rd_data_a <= DATA_RESET;
      rd_data_b <= DATA_RESET;
    end else begin
      mem_reg   <= mem_next;
      rd_data_a <= rd_a_next;
      rd_data_b <= rd_b_next;
    end
  end

endmodule : host_reg_mem
`default_nettype wire

// *** pin_mux_assertions.sv ***
// Concurrent checks on the ports of the host pin and parallel port multiplexer.
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker
  import pin_mux_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        host_select_n,
  input wire logic        host_read_n,
  input wire logic        host_driver_disable_n,
  input wire logic [7:0]  port_a_lines_oe,
  input wire logic [7:0]  port_c_lines_oe,
  input wire logic [7:0]  serial_a_alt_oe,
  input wire logic        alt_irq_pin,
  input wire logic        host_irq
);
  logic [9:0] cfg, cfg_q;
  logic [1:0] age;
  logic       ok, hm, nh, pca;

  // The shadow lags the design by one edge, so only settled configurations are judged.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg   <= CONFIG_RESET;
      cfg_q <= CONFIG_RESET;
      age   <= 2'h0;
    end else begin
      if (psel && penable && pready && pwrite && !pslverr && paddr == OFF_CONFIG) begin
        cfg <= pwdata[9:0];
      end
      cfg_q <= cfg;
      if (age != 2'h3) begin
        age <= age + 2'h1;
      end
    end
  end

  assign ok  = (age == 2'h3);
  assign hm  = cfg[CFG_HOST_MODE_BIT] && cfg_q[CFG_HOST_MODE_BIT];
  assign nh  = !cfg[CFG_HOST_MODE_BIT] && !cfg_q[CFG_HOST_MODE_BIT];
  assign pca = !cfg[CFG_PORT_C_BIT] && !cfg_q[CFG_PORT_C_BIT];

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_host_read_end;
    (!host_select_n && !host_read_n) ##1 host_read_n;
  endsequence

  a_ready_answer: assert property (s_access |=> pready ##1 !pready)
    else $error("ready pulse missing or too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without an access phase");
  a_err_quiet: assert property (!pready |-> !pslverr && prdata == 32'h0)
    else $error("read data or error outside the answer");
  a_read_sync: assert property (hm && $fell(host_driver_disable_n) |->
    $past(!host_select_n && !host_read_n, 3))
    else $error("driver disable fell too early");
  a_read_release: assert property (hm && ok ##0 s_host_read_end |->
    !host_driver_disable_n [*3] ##1 host_driver_disable_n)
    else $error("driver disable released at the wrong time");
  a_bus_follows: assert property (hm |-> port_a_lines_oe == {8{!host_driver_disable_n}})
    else $error("host data drive not tied to the read");
  a_pc_top_in: assert property (port_c_lines_oe[7:6] == 2'b00)
    else $error("port C top bits driven");
  a_pc_alt: assert property (ok && pca |-> port_c_lines_oe[5:0] == $past(serial_a_alt_oe[5:0]))
    else $error("port C does not follow the serial channel");
  a_irq_alt: assert property (ok && nh |-> host_irq == $past(alt_irq_pin))
    else $error("shared interrupt pin not on its alternate function");
endmodule : pin_mux_checker

bind host_pins_parallel_io_mux pin_mux_checker chk_i (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .host_select_n(host_select_n), .host_read_n(host_read_n),
  .host_driver_disable_n(host_driver_disable_n), .port_a_lines_oe(port_a_lines_oe),
  .port_c_lines_oe(port_c_lines_oe), .serial_a_alt_oe(serial_a_alt_oe),
  .alt_irq_pin(alt_irq_pin), .host_irq(host_irq)
);
`default_nettype wire

// *** host_bus_model.sv ***
// Behavioural host computer on the expansion bus side of the shared pins.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import pin_mux_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  input  wire logic [7:0] idle_val,
  input  wire logic       dis_n,
  output var host_pins_t  pins,
  output logic      [7:0] bus
);
  logic drive = 1'b0;

  initial begin
    pins = {1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
  end

  // Lines nobody drives show a bench value, never the last data byte.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus[i] = dev_oe[i] ? dev_out[i] : (drive ? pins.data[i] : idle_val[i]);
    end
  end

  // One byte access; the strobe is held six cycles and the gap is six, above the minimums.
  task automatic access(input logic wr, input logic [2:0] idx, input logic [7:0] d,
                        output logic [7:0] rd, output logic dn);
    pins.select_n  <= 1'b0;
    pins.reg_index <= idx;
    pins.data      <= d;
    drive          <= wr;
    pins.write_n   <= !wr;
    pins.read_n    <= wr;
    repeat (6) @(posedge clk);
    rd = bus;
    dn = dis_n;
    pins.select_n <= 1'b1;
    pins.write_n  <= 1'b1;
    pins.read_n   <= 1'b1;
    // Data outlasts the strobe because the device sees the strobe edge only after syncing.
    repeat (4) @(posedge clk);
    drive <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : access
endmodule : host_bus_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the host pin and parallel port multiplexer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pin_mux_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, pb_in = 8'h96, pc_in = 8'h0f, idle_val = 8'hc3;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, irq, e, dn, dis_n, h_irq, txr_n, rxr_n;
  logic [7:0]  pa_out, pa_oe, pa_in, pb_out, pb_oe, pc_out, pc_oe, hd;
  logic [7:0]  sb_out = 8'h00, sb_oe = 8'h00, sa_out = 8'h00, sa_oe = 8'h00;
  logic        ext_one_n = 1'b1, ext_two_n = 1'b1;
  logic        a_tx_b = 1'b0, a_irq = 1'b0, a_txr = 1'b0, a_rxr = 1'b0;
  host_pins_t  hp;
  int          n_errors = 0, cmp_count = 0, cycles = 0;
  logic [3:0]  sv [5] = '{4'h8, 4'h5, 4'h6, 4'h4, 4'h0};

  host_pins_parallel_io_mux DUT (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .port_a_lines_in(pa_in), .port_a_lines_out(pa_out), .port_a_lines_oe(pa_oe),
    .port_b_lines_in(pb_in), .port_b_lines_out(pb_out), .port_b_lines_oe(pb_oe),
    .port_c_lines_in(pc_in), .port_c_lines_out(pc_out), .port_c_lines_oe(pc_oe),
    .ext_irq_one_n(ext_one_n), .ext_irq_two_n(ext_two_n), .host_select_n(hp.select_n),
    .host_write_n(hp.write_n), .host_read_n(hp.read_n), .host_reg_index(hp.reg_index),
    .serial_b_alt_out(sb_out), .serial_b_alt_oe(sb_oe), .serial_a_alt_out(sa_out),
    .serial_a_alt_oe(sa_oe), .alt_tx_b(a_tx_b), .alt_irq_pin(a_irq),
    .alt_tx_ready_pin(a_txr), .alt_rx_ready_pin(a_rxr), .host_driver_disable_n(dis_n),
    .host_irq(h_irq), .host_tx_ready_n(txr_n), .host_rx_ready_n(rxr_n)
  );
  host_bus_model host (
    .clk(clk), .dev_out(pa_out), .dev_oe(pa_oe), .idle_val(idle_val), .dis_n(dis_n),
    .pins(hp), .bus(pa_in)
  );

  always #50 clk = ~clk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // The whole run needs fewer than three hundred cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) n_errors++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask : rdc

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(OFF_CONFIG, 32'h3ff, {22'h0, CONFIG_RESET});
    rdc(OFF_STATUS, 32'hf, {28'h0, STATUS_RESET});
    rdc(OFF_IRQ_MASK, 32'hf, {28'h0, MASK_RESET});
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    for (int k = 0; k < 2; k++) begin
      {a_tx_b, a_irq, a_txr, a_rxr} <= k ? 4'h9 : 4'h6;
      {sb_out, sb_oe, sa_out, sa_oe} <= k ? 32'h5aa53c0f : 32'hc33c2a15;
      repeat (3) @(posedge clk);
      chk({12'h0, h_irq, txr_n, rxr_n, dis_n, pb_oe, pb_out},
          {12'h0, a_irq, a_txr, a_rxr, a_tx_b, sb_oe, sb_out});
      chk({20'h0, pc_oe[5:0], pc_out[5:0]}, {20'h0, sa_oe[5:0], sa_out[5:0]});
    end
    apb(1'b1, OFF_PA_DIR, 32'h0f);
    apb(1'b1, OFF_PA_DATA, 32'h5a);
    repeat (2) @(posedge clk);
    chk({16'h0, pa_oe, pa_out & pa_oe}, 32'h0f0a);
    rdc(OFF_PA_DATA, 32'hff, 32'hca);
    host.access(1'b0, 3'h0, 8'h00, hd, dn);
    chk({23'h0, dn, pa_oe}, {23'h0, a_tx_b, 8'h0f});
    host.access(1'b1, 3'h5, 8'h77, hd, dn);
    rdc(OFF_IRQ_STAT, 32'h3, 32'h0);
    apb(1'b1, OFF_CONFIG, 32'h84);
    apb(1'b1, OFF_PB_DIR, 32'hf0);
    apb(1'b1, OFF_PB_DATA, 32'h99);
    apb(1'b1, OFF_PC_DIR, 32'hff);
    apb(1'b1, OFF_PC_DATA, 32'h3f);
    ext_one_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({pb_oe, pb_out & pb_oe, pc_oe, pc_out & pc_oe}, 32'hf0903f3f);
    rdc(OFF_PC_DATA, 32'hc0, 32'h80);
    ext_one_n <= 1'b1;
    apb(1'b1, OFF_CONFIG, 32'h384);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    for (int k = 0; k < 2; k++) begin
      ext_one_n <= (k != 0);
      ext_two_n <= (k == 0);
      repeat (4) @(posedge clk);
      ext_one_n <= 1'b1;
      ext_two_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFF_IRQ_MASK, 32'h4 << k);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, OFF_PC_DATA, 32'h0);
      rdc(OFF_IRQ_STAT, 32'h3c, 32'h14 << k);
      apb(1'b1, OFF_PC_DATA, 32'h40 << k);
      rdc(OFF_IRQ_STAT, 32'h3c, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
    end
    apb(1'b1, OFF_CONFIG, 32'h2);
    apb(1'b1, OFF_HOST_DATA, 32'h3c);
    chk({24'h0, pa_oe}, 32'h0);
    host.access(1'b0, HOST_IDX_DATA, 8'h00, hd, dn);
    chk({23'h0, dn, hd}, 32'h03c);
    chk({23'h0, dis_n, pa_oe}, 32'h100);
    host.access(1'b1, 3'h5, 8'ha5, hd, dn);
    rdc(OFF_HOST_REGS + 8'h14, 32'hff, 32'ha5);
    apb(1'b1, 8'h74, 32'h55);
    chk({31'h0, e}, 32'h1);
    host.access(1'b0, 3'h5, 8'h00, hd, dn);
    chk({24'h0, hd}, 32'ha5);
    host.access(1'b1, HOST_IDX_DATA, 8'h11, hd, dn);
    rdc(OFF_STATUS, 32'h1, 32'h0);
    rdc(OFF_IRQ_STAT, 32'h3, 32'h3);
    foreach (sv[i]) begin
      apb(1'b1, OFF_STATUS, {28'h0, sv[i]});
      @(posedge clk);
      chk({29'h0, h_irq, txr_n, rxr_n},
          {29'h0, sv[i][3], ~(sv[i][2] & sv[i][0]), ~(sv[i][2] & sv[i][1])});
    end
    results();
  end
endmodule : tb
`default_nettype wire
